// ### core/notch_bank_pkg.sv
// Purpose: shared constants and types of the notch filter bank
// Assumes: 250 MHz pclk, registers on APB at 32-bit aligned words
// Notes:   frequencies are held in whole Hz, 12 bits wide
package notch_bank_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ     = 250;
   localparam int GATE_MS     = 500;
   localparam int GATE_CYCLES = GATE_MS * CLK_MHZ * 1000;

   // ****************************************
   // frequencies in hz
   // ****************************************
   localparam logic [11:0] FIXED_NOTCH_HZ = 12'h465;
   localparam logic [11:0] MAX_HZ         = 12'h8CA;
   localparam logic [11:0] EST_MIN_HZ     = 12'h096;
   localparam logic [11:0] EST_MAX_HZ     = 12'h384;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] ADDR_DEPTH_A   = 8'h00;
   localparam logic [7:0] ADDR_FREQ_ONE  = 8'h04;
   localparam logic [7:0] ADDR_FREQ_TWO  = 8'h08;
   localparam logic [7:0] ADDR_DEPTH_B   = 8'h0C;
   localparam logic [7:0] ADDR_FREQ_FOUR = 8'h10;
   localparam logic [7:0] ADDR_FREQ_FIVE = 8'h14;
   localparam logic [7:0] ADDR_TRACK     = 8'h18;
   localparam logic [7:0] ADDR_ESTIMATE  = 8'h1C;
   localparam logic [7:0] ADDR_EFF_ONE   = 8'h20;
   localparam logic [7:0] ADDR_EFF_TWO   = 8'h24;
   localparam logic [7:0] ADDR_EFF_FOUR  = 8'h28;
   localparam logic [7:0] ADDR_EFF_FIVE  = 8'h2C;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int DEPTH_HI_LSB  = 5;
   localparam int FIXED_RUN_BIT = 4;
   localparam int DEPTH_LO_LSB  = 1;
   localparam int TRACK_EN_LSB  = 8;
   localparam int RANGE_LSB     = 4;
   localparam int ALL_FREQ_BIT  = 15;
   localparam logic [15:0] REG_RESET = 16'h0000;

   typedef enum logic [0:0] {TRK_IDLE, TRK_GATE} trk_t;

   // settings handed to the filter arithmetic; index 0..3 = filters 1,2,4,5
   typedef struct packed {
      logic [3:0][11:0] eff_hz;
      logic [3:0]       notch_on;
      logic [2:0]       depth_code_filter_one;
      logic [2:0]       depth_code_filter_two;
      logic [2:0]       depth_code_filter_four;
      logic [2:0]       depth_code_filter_five;
      logic             fixed_notch_run;
      logic [11:0]      fixed_hz;
   } filter_setting_t;
endpackage

// ### core/adaptive_notch_filter_bank.sv
// Purpose: settings and adaptive tracking of a five-filter notch bank
// Assumes: inputs synchronous to pclk, APB slave with no wait states
// Notes:   resonance is measured by zero crossings over a 0.5 s gate
// Summary of operation
// - five notches; the third sits fixed at 1125 Hz without depth.
// - word two bits 7..5 pick filter two depth, eight steps.
// - word two bit 4 stops or starts the fixed notch.
// - word two bits 3..1 pick filter one depth, same steps.
// - word six bits 7..5 pick filter five depth.
// - word six bits 3..1 pick filter four depth.
// - filters 1,2,4,5 take 0..2250 Hz; zero turns the filter off.
// - estimated resonance is readable; zero means none present.
// - estimate during rapid traverse, retune only while stopped.
// - only filters 1,2,4,5 are retuned, never the fixed one.
// - estimates outside 150..900 Hz are discarded.
// - tracking moves frequency only, depth stays as programmed.
// - retune the in-window filter whose setting is nearest.
// - filter five with all-frequency mode takes what others cannot.
// - new setting keeps effective value if still in its window.
// - word ten bit 15 widens filter five window to 150..900 Hz.
// - word ten bits 8..11 enable tracking for filters 1,2,4,5.
// - word ten bits 5..4 set window to 10,20,30 or 40 percent.
`timescale 1ns/1ns
`default_nettype none
module adaptive_notch_filter_bank #(
   parameter int unsigned GATE_CYCLES = notch_bank_pkg::GATE_CYCLES
) (
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [7:0]                      paddr,
   input  wire logic [31:0]                     pwdata,
   input  wire logic [3:0]                      pstrb,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic [15:0]                     current_cmd,
   input  wire logic                            current_valid,
   input  wire logic                            rapid_traverse_motion,
   input  wire logic                            axis_stopped,
   output logic      [11:0]                     resonance_estimate_monitor,
   output notch_bank_pkg::filter_setting_t      filter_settings
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (GATE_CYCLES < 2) begin : g_bad_gate
      $error("GATE_CYCLES must be at least 2");
   end

   localparam logic [31:0] GATE_LAST = 32'(GATE_CYCLES - 1);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [11:0] abs_diff(input logic [11:0] a,
                                            input logic [11:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   // window in hz: setting * 10*(code+1) percent
   function automatic logic [11:0] window_hz(input logic [11:0] p,
                                             input logic [1:0]  code);
      logic [15:0] t;
      logic [15:0] w;
      t = {4'h0, p};
      w = (t * {14'h0000, code} + t) / 16'h000A;
      return w[11:0];
   endfunction

   function automatic logic in_window(input logic [11:0] f,
                                      input logic [11:0] p,
                                      input logic [1:0]  code);
      return abs_diff(f, p) <= window_hz(p, code);
   endfunction

   function automatic logic [11:0] clamp_hz(input logic [15:0] v);
      return (v > {4'h0, notch_bank_pkg::MAX_HZ}) ?
             notch_bank_pkg::MAX_HZ : v[11:0];
   endfunction

   function automatic logic in_band(input logic [11:0] f);
      return f >= notch_bank_pkg::EST_MIN_HZ &&
             f <= notch_bank_pkg::EST_MAX_HZ;
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  sb);
      return {sb[1] ? wd[15:8] : old[15:8], sb[0] ? wd[7:0] : old[7:0]};
   endfunction

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [15:0]       depth_a;
      logic [15:0]       depth_b;
      logic [15:0]       track;
      logic [3:0][15:0]  prog;
      logic [3:0][11:0]  eff;
      logic [11:0]       est;
      logic              pend;
      notch_bank_pkg::trk_t trk;
      logic [31:0]       gate_cnt;
      logic [11:0]       xcnt;
      logic              sign_q;
      logic [31:0]       prdata;
   } state_t;

   state_t            st;
   state_t            nx;
   logic              wr_en;
   logic              mapped;
   logic              freq_wr;
   logic [1:0]        freq_idx;
   logic [1:0]        range_code;
   logic [3:0]        cand;
   logic [3:0][11:0]  prog_hz;
   logic [11:0]       best_d;
   logic [1:0]        sel;
   logic              found;
   logic [15:0]       new_prog;
   logic [11:0]       new_hz;

   assign wr_en      = psel && penable && pwrite;
   assign range_code = st.track[notch_bank_pkg::RANGE_LSB +: 2];
   assign new_prog   = merge16(st.prog[freq_idx], pwdata, pstrb);
   assign new_hz     = clamp_hz(new_prog);

   // ****************************************
   // address decode
   // ****************************************
   always_comb begin
      mapped   = 1'b1;
      freq_wr  = 1'b0;
      freq_idx = 2'h0;
      unique case (paddr)
         notch_bank_pkg::ADDR_FREQ_ONE: begin
            freq_wr  = wr_en;
            freq_idx = 2'h0;
         end
         notch_bank_pkg::ADDR_FREQ_TWO: begin
            freq_wr  = wr_en;
            freq_idx = 2'h1;
         end
         notch_bank_pkg::ADDR_FREQ_FOUR: begin
            freq_wr  = wr_en;
            freq_idx = 2'h2;
         end
         notch_bank_pkg::ADDR_FREQ_FIVE: begin
            freq_wr  = wr_en;
            freq_idx = 2'h3;
         end
         notch_bank_pkg::ADDR_DEPTH_A,
         notch_bank_pkg::ADDR_DEPTH_B,
         notch_bank_pkg::ADDR_TRACK,
         notch_bank_pkg::ADDR_ESTIMATE,
         notch_bank_pkg::ADDR_EFF_ONE,
         notch_bank_pkg::ADDR_EFF_TWO,
         notch_bank_pkg::ADDR_EFF_FOUR,
         notch_bank_pkg::ADDR_EFF_FIVE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ****************************************
   // nearest in-window filter
   // ****************************************
   always_comb begin
      best_d = 12'hFFF;
      sel    = 2'h0;
      found  = 1'b0;
      for (int i = 0; i < 4; i++) begin
         prog_hz[i] = clamp_hz(st.prog[i]);
         cand[i] = st.track[notch_bank_pkg::TRACK_EN_LSB + i] &&
                   prog_hz[i] != 12'h000 &&
                   in_window(st.est, prog_hz[i], range_code);
         if (cand[i] && abs_diff(st.est, prog_hz[i]) < best_d) begin
            best_d = abs_diff(st.est, prog_hz[i]);
            sel    = 2'(i);
            found  = 1'b1;
         end
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nx = st;
      if (current_valid) begin
         nx.sign_q = current_cmd[15];
      end
      unique case (st.trk)
         notch_bank_pkg::TRK_IDLE: begin
            if (rapid_traverse_motion) begin
               nx.trk      = notch_bank_pkg::TRK_GATE;
               nx.gate_cnt = 32'h0000_0000;
               nx.xcnt     = 12'h000;
            end
         end
         notch_bank_pkg::TRK_GATE: begin
            if (!rapid_traverse_motion) begin
               nx.trk = notch_bank_pkg::TRK_IDLE;
            end else begin
               nx.gate_cnt = st.gate_cnt + 32'h0000_0001;
               if (current_valid && current_cmd[15] != st.sign_q &&
                   st.xcnt != 12'hFFF) begin
                  nx.xcnt = st.xcnt + 12'h001;
               end
               if (st.gate_cnt == GATE_LAST) begin
                  nx.trk = notch_bank_pkg::TRK_IDLE;
                  nx.est  = in_band(st.xcnt) ? st.xcnt : 12'h000;
                  nx.pend = in_band(st.xcnt);
               end
            end
         end
      endcase
      if (st.pend && axis_stopped && !rapid_traverse_motion) begin
         nx.pend = 1'b0;
         // only the four tunable slots exist here
         if (found) begin
            nx.eff[sel] = st.est;
         end else if (st.track[notch_bank_pkg::ALL_FREQ_BIT] &&
                      st.track[notch_bank_pkg::TRACK_EN_LSB + 3] &&
                      prog_hz[3] != 12'h000) begin
            // full band window for filter five
            nx.eff[3] = st.est;
         end
      end
      if (wr_en) begin
         unique case (paddr)
            notch_bank_pkg::ADDR_DEPTH_A:
               nx.depth_a = merge16(st.depth_a, pwdata, pstrb);
            notch_bank_pkg::ADDR_DEPTH_B:
               nx.depth_b = merge16(st.depth_b, pwdata, pstrb);
            notch_bank_pkg::ADDR_TRACK:
               nx.track = merge16(st.track, pwdata, pstrb);
            default: ;
         endcase
      end
      // keep effective value if still inside new window
      if (freq_wr) begin
         nx.prog[freq_idx] = new_prog;
         nx.eff[freq_idx]  = in_window(st.eff[freq_idx], new_hz,
                                       range_code) ?
                             st.eff[freq_idx] : new_hz;
      end
      // read data captured in the setup phase
      if (psel && !penable) begin
         unique case (paddr)
            notch_bank_pkg::ADDR_DEPTH_A:   nx.prdata = {16'h0, st.depth_a};
            notch_bank_pkg::ADDR_FREQ_ONE:  nx.prdata = {16'h0, st.prog[0]};
            notch_bank_pkg::ADDR_FREQ_TWO:  nx.prdata = {16'h0, st.prog[1]};
            notch_bank_pkg::ADDR_DEPTH_B:   nx.prdata = {16'h0, st.depth_b};
            notch_bank_pkg::ADDR_FREQ_FOUR: nx.prdata = {16'h0, st.prog[2]};
            notch_bank_pkg::ADDR_FREQ_FIVE: nx.prdata = {16'h0, st.prog[3]};
            notch_bank_pkg::ADDR_TRACK:     nx.prdata = {16'h0, st.track};
            notch_bank_pkg::ADDR_ESTIMATE:  nx.prdata = {20'h0, st.est};
            notch_bank_pkg::ADDR_EFF_ONE:   nx.prdata = {20'h0, st.eff[0]};
            notch_bank_pkg::ADDR_EFF_TWO:   nx.prdata = {20'h0, st.eff[1]};
            notch_bank_pkg::ADDR_EFF_FOUR:  nx.prdata = {20'h0, st.eff[2]};
            notch_bank_pkg::ADDR_EFF_FIVE:  nx.prdata = {20'h0, st.eff[3]};
            default:                        nx.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.depth_a  <= notch_bank_pkg::REG_RESET;
         st.depth_b  <= notch_bank_pkg::REG_RESET;
         st.track    <= notch_bank_pkg::REG_RESET;
         st.prog     <= '0;
         st.eff      <= '0;
         st.est      <= 12'h000;
         st.pend     <= 1'b0;
         st.trk      <= notch_bank_pkg::TRK_IDLE;
         st.gate_cnt <= 32'h0000_0000;
         st.xcnt     <= 12'h000;
         st.sign_q   <= 1'b0;
         st.prdata   <= 32'h0000_0000;
      end else begin
         st <= nx;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata  = st.prdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign resonance_estimate_monitor = st.est;

   always_comb begin
      filter_settings.eff_hz = st.eff;
      // zero setting turns a filter off
      for (int i = 0; i < 4; i++) begin
         filter_settings.notch_on[i] = st.prog[i] != 16'h0000;
      end
      filter_settings.depth_code_filter_two =
         st.depth_a[notch_bank_pkg::DEPTH_HI_LSB +: 3];
      filter_settings.depth_code_filter_one =
         st.depth_a[notch_bank_pkg::DEPTH_LO_LSB +: 3];
      filter_settings.depth_code_filter_five =
         st.depth_b[notch_bank_pkg::DEPTH_HI_LSB +: 3];
      filter_settings.depth_code_filter_four =
         st.depth_b[notch_bank_pkg::DEPTH_LO_LSB +: 3];
      filter_settings.fixed_notch_run =
         st.depth_a[notch_bank_pkg::FIXED_RUN_BIT];
      filter_settings.fixed_hz = notch_bank_pkg::FIXED_NOTCH_HZ;
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_est_setup;
      psel && !penable && !pwrite &&
      paddr == notch_bank_pkg::ADDR_ESTIMATE;
   endsequence

   sequence s_access;
      psel && penable;
   endsequence

   a_fixed_run_set: assert property (
      wr_en && paddr == notch_bank_pkg::ADDR_DEPTH_A && pstrb[0]
      |=> filter_settings.fixed_notch_run == $past(pwdata[4]))
      else $error("fixed notch run bit not taken");

   a_depth_two_set: assert property (
      wr_en && paddr == notch_bank_pkg::ADDR_DEPTH_A && pstrb[0]
      |=> filter_settings.depth_code_filter_two == $past(pwdata[7:5]))
      else $error("filter two depth not taken");

   a_depth_one_set: assert property (
      wr_en && paddr == notch_bank_pkg::ADDR_DEPTH_A && pstrb[0]
      |=> filter_settings.depth_code_filter_one == $past(pwdata[3:1]))
      else $error("filter one depth not taken");

   a_depth_b_set: assert property (
      wr_en && paddr == notch_bank_pkg::ADDR_DEPTH_B && pstrb[0]
      |=> filter_settings.depth_code_filter_five == $past(pwdata[7:5]) &&
          filter_settings.depth_code_filter_four == $past(pwdata[3:1]))
      else $error("filter four or five depth not taken");

   a_depth_held: assert property (
      !(wr_en && (paddr == notch_bank_pkg::ADDR_DEPTH_A ||
                  paddr == notch_bank_pkg::ADDR_DEPTH_B))
      |=> $stable({st.depth_a[7:1], st.depth_b[7:1]}))
      else $error("depth changed without a host write");

   a_est_band: assert property (
      st.est != 12'h000 |-> in_band(st.est))
      else $error("estimate outside band");

   a_est_in_rapid: assert property (
      $changed(st.est) |-> $past(rapid_traverse_motion))
      else $error("estimate changed outside rapid traverse");

   a_eff_when_stop: assert property (
      !axis_stopped && !freq_wr |=> $stable(st.eff))
      else $error("effective frequency moved while axis moving");

   a_param_adopt: assert property (
      freq_wr && !in_window(st.eff[freq_idx], new_hz, range_code)
      |=> st.eff[$past(freq_idx)] == $past(new_hz))
      else $error("new setting not adopted");

   a_read_est: assert property (
      s_est_setup ##1 s_access |-> prdata == $past(st.est))
      else $error("estimate read back wrong");

   a_slverr_map: assert property (
      psel && penable && !mapped |-> pslverr ##1 !pslverr || psel)
      else $error("unmapped access not flagged");

endmodule // adaptive_notch_filter_bank
`default_nettype wire

// ### verif/host_apb_model.sv
// Purpose: host controller that programs the notch bank over APB
// Assumes: pready is sampled at rising pclk, one transfer at a time
// Notes:   idle address and data lines show inverted last values
`timescale 1ns/1ns
`default_nettype none
module host_apb_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // ****************************************
   // bus transfer
   // ****************************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h3;
   end

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // host_apb_model
`default_nettype wire

// ### verif/tb_adaptive_notch_filter_bank.sv
// Purpose: self-checking bench of the adaptive notch filter bank
// Assumes: short estimation gate, host model on the register bus
// Notes:   estimate equals the sign changes seen within one gate, or zero when outside 150..900
`timescale 1ns/1ns
`default_nettype none
module tb_adaptive_notch_filter_bank;
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] data;
      logic [15:0] rexp;
      logic        err;
   } row_t;
   localparam int GATE = 1000;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [15:0] cur = 16'h0000;
   logic        cv = 1'b0;
   logic        rapid = 1'b0;
   logic        stopped = 1'b0;
   logic [11:0] est;
   int          fail_count = 0;
   int          compares = 0;
   notch_bank_pkg::filter_setting_t fs;
   row_t rows [9] = '{
      '{notch_bank_pkg::ADDR_DEPTH_A, 16'h00BE, 16'h00BE, 1'b0},
      '{notch_bank_pkg::ADDR_DEPTH_B, 16'h0062, 16'h0062, 1'b0},
      '{notch_bank_pkg::ADDR_FREQ_ONE, 16'h0190, 16'h0190, 1'b0},
      '{notch_bank_pkg::ADDR_FREQ_TWO, 16'h0320, 16'h0320, 1'b0},
      '{notch_bank_pkg::ADDR_FREQ_FOUR, 16'h0258, 16'h0258, 1'b0},
      '{notch_bank_pkg::ADDR_FREQ_FIVE, 16'h08CA, 16'h08CA, 1'b0},
      '{notch_bank_pkg::ADDR_TRACK, 16'h8F10, 16'h8F10, 1'b0},
      '{8'h30, 16'h1234, 16'h0000, 1'b1},
      '{notch_bank_pkg::ADDR_ESTIMATE, 16'h0055, 16'h0000, 1'b0}};

   always #2 pclk = ~pclk;

   host_apb_model host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   adaptive_notch_filter_bank #(.GATE_CYCLES(GATE)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .current_cmd(cur), .current_valid(cv),
      .rapid_traverse_motion(rapid), .axis_stopped(stopped),
      .resonance_estimate_monitor(est), .filter_settings(fs));

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host.xfer(1'b1, a, {16'h0000, d}, rd, err);
      repeat (2) @(posedge pclk);
   endtask

   // k sign changes in one gate, then abort the next gate
   task automatic run_est(input int k, input logic [11:0] exp);
      @(posedge pclk);
      rapid <= 1'b1;
      stopped <= 1'b0;
      repeat (3) @(posedge pclk);
      for (int i = 0; i < k; i++) begin
         cur <= i[0] ? 16'h0001 : 16'h8001;
         cv <= 1'b1;
         @(posedge pclk);
      end
      cv <= 1'b0;
      repeat (GATE + 500 - k) @(posedge pclk);
      rapid <= 1'b0;
      @(posedge pclk);
      check(est, exp);
   endtask

   task automatic stop_test();
      if (fail_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      stop_test();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         host.xfer(1'b1, rows[i].addr, {16'h0000, rows[i].data}, rd, err);
         check(err, rows[i].err);
         host.xfer(1'b0, rows[i].addr, 32'h0, rd, err);
         check(rd, rows[i].rexp);
      end
      check(fs.fixed_hz, 12'h465);
      check(fs.depth_code_filter_two, 3'h5);
      check(fs.fixed_notch_run, 1'b1);
      check(fs.depth_code_filter_one, 3'h7);
      check(fs.depth_code_filter_five, 3'h3);
      check(fs.depth_code_filter_four, 3'h1);
      check(fs.notch_on, 4'hF);
      check(fs.eff_hz, 48'h8CA_258_320_190);
      run_est(470, 12'h1D6);
      check(fs.eff_hz, 48'h8CA_258_320_190);
      stopped <= 1'b1;
      repeat (4) @(posedge pclk);
      check(fs.eff_hz, 48'h8CA_258_320_1D6);
      check(fs.depth_code_filter_one, 3'h7);
      check(fs.fixed_notch_run, 1'b1);
      run_est(300, 12'h12C);
      stopped <= 1'b1;
      repeat (4) @(posedge pclk);
      check(fs.eff_hz, 48'h12C_258_320_1D6);
      run_est(100, 12'h000);
      wr(notch_bank_pkg::ADDR_FREQ_ONE, 16'h01C2);
      check(fs.eff_hz[0], 12'h1D6);
      wr(notch_bank_pkg::ADDR_FREQ_ONE, 16'h0064);
      check(fs.eff_hz[0], 12'h064);
      wr(notch_bank_pkg::ADDR_FREQ_FOUR, 16'h0000);
      check(fs.notch_on, 4'hB);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check(fs.eff_hz, 48'h0);
      check(pready, 1'b1);
      presetn <= 1'b1;
      host.xfer(1'b0, notch_bank_pkg::ADDR_TRACK, 32'h0, rd, err);
      check(rd, 32'h0);
      stop_test();
   end
endmodule // tb_adaptive_notch_filter_bank
`default_nettype wire
